// file: edp_ddc_assertions.sv
// concurrent checks on the edid provisioning top ports
`timescale 1ns/10ps
module edp_ddc_assertions import edp_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic pwr5v_i,
	input wire logic hpd_o,
	input wire logic hpd_oe_o,
	input wire logic load_done_o,
	input wire logic lm_rd_i,
	input wire logic [7:0] lm_rdata_o,
	input wire logic fuse_rd_o,
	input wire logic [7:0] fuse_addr_o,
	input wire logic rem_req_o,
	input wire logic [6:0] rem_dev_o,
	input wire logic [7:0] rem_addr_o,
	input wire logic rem_ack_i,
	input wire logic rem_err_i
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_not_ready;
		!load_done_o ##1 !load_done_o;
	endsequence
	sequence s_fuse_pair;
		fuse_rd_o ##2 fuse_rd_o;
	endsequence
	AST_HPD_ZERO: assert property (hpd_o == 1'b0)
		else $error("hot-plug drive value not low");
	AST_LD_HPD: assert property (s_not_ready |-> hpd_oe_o)
		else $error("hot-plug released while not ready");
	AST_HPD_5V: assert property ($fell(pwr5v_i) |-> ##[1:5] hpd_oe_o)
		else $error("hot-plug not held after supply loss");
	AST_FUSE_SPACE: assert property (fuse_rd_o |=> !fuse_rd_o)
		else $error("fuse reads too close");
	AST_FUSE_STEP: assert property (
		s_fuse_pair |-> fuse_addr_o == $past(fuse_addr_o, 2) + 8'h01)
		else $error("fuse address did not step by one");
	AST_REM_DEV: assert property (rem_req_o |-> rem_dev_o == EDP_REM_DEV)
		else $error("remote device address wrong");
	AST_REM_ADV: assert property (
		rem_req_o && rem_ack_i && !rem_err_i && rem_addr_o != EDP_LAST_BYTE
		|=> rem_addr_o == $past(rem_addr_o) + 8'h01)
		else $error("remote offset did not advance");
	AST_REM_END: assert property (
		rem_req_o && rem_ack_i && !rem_err_i && rem_addr_o == EDP_LAST_BYTE |=> !rem_req_o)
		else $error("remote request kept after last byte");
	AST_REM_ERR: assert property (rem_req_o && rem_err_i |=> rem_addr_o == 8'h00)
		else $error("remote copy did not restart");
	AST_RD_HOLD: assert property (!lm_rd_i |=> $stable(lm_rdata_o))
		else $error("read data changed without a read");
endmodule : edp_ddc_assertions

// file: edp_ddc_top.sv
// display identification store, loader, ddc slave and hot-plug control
//
// Overview of operation
// - source is chosen from eeprom, loaded sram, remote copy or fuse, by pins or control.
// - identification data is served on the ddc bus at device address 0xa0 in sram, remote and fuse modes.
// - eeprom mode passes the ddc bus to a local eeprom of any size up to 32KB.
// - a 256-byte volatile store holds the profile once a local or remote master loads it.
// - the store can be rewritten and read back through the control port during operation.
// - remote mode fetches the 0xa0 data over the serial link control channel into sram.
// - fuse mode copies the 256-byte fused profile into sram at start-up and serves it.
// - the fused profile advertises 480p, 720p, 2-channel audio within 25 to 96 MHz.
// - remote accesses ride the serial link control channel and restart the copy from offset 0 after lost arbitration.
// - hot-plug is held low until the sink is ready with 5v present, then released to be pulled high.
`timescale 1ns/10ps
module edp_ddc_top import edp_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic ddc_scl_i,
	input wire logic ddc_sda_i,
	output logic ddc_sda_oe_o,
	input wire logic eep_sda_i,
	output logic eep_scl_oe_o,
	output logic eep_sda_oe_o,
	input wire logic [1:0] mode_sel_i,
	input wire logic mode_ovr_en_i,
	input wire logic [1:0] mode_ovr_i,
	input wire logic pwr5v_i,
	output logic hpd_o,
	output logic hpd_oe_o,
	output logic load_done_o,
	input wire logic lm_wr_i,
	input wire logic lm_rd_i,
	input wire logic [7:0] lm_addr_i,
	input wire logic [7:0] lm_wdata_i,
	output logic [7:0] lm_rdata_o,
	output logic fuse_rd_o,
	output logic [7:0] fuse_addr_o,
	input wire logic [7:0] fuse_data_i,
	output logic rem_req_o,
	output logic [6:0] rem_dev_o,
	output logic [7:0] rem_addr_o,
	input wire logic rem_ack_i,
	input wire logic rem_err_i,
	input wire logic [7:0] rem_data_i
);
	logic [7:0] mem [0:255];
	logic [EDP_SYNC_W-1:0] pins, s1, s2, s3;
	logic scl_s, sda_s, eep_sda_s, pwr_s, scl_p, sda_p;
	logic [1:0] msel_s, mode_now;
	logic start_ev, stop_ev, rise_ev, fall_ev;

	// pin inputs pass two flops; s3 only keeps the previous value for edges
	assign pins = {ddc_scl_i, ddc_sda_i, eep_sda_i, pwr5v_i, mode_sel_i};
	for (genvar g = 0; g < EDP_SYNC_W; g++) begin : g_sync
		always_ff @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				s1[g] <= 1'b1;
				s2[g] <= 1'b1;
				s3[g] <= 1'b1;
			end else begin
				s1[g] <= pins[g];
				s2[g] <= s1[g];
				s3[g] <= s2[g];
			end
		end
	end
	assign scl_s = s2[5];
	assign sda_s = s2[4];
	assign eep_sda_s = s2[3];
	assign pwr_s = s2[2];
	assign msel_s = s2[1:0];
	assign scl_p = s3[5];
	assign sda_p = s3[4];
	assign start_ev = scl_s & sda_p & ~sda_s;
	assign stop_ev = scl_s & ~sda_p & sda_s;
	assign rise_ev = scl_s & ~scl_p;
	assign fall_ev = ~scl_s & scl_p;
	assign mode_now = mode_ovr_en_i ? mode_ovr_i : msel_s;

	// loader: fills the store from fuses or the remote bus
	edp_ld_t ld_state, next_ld_state;
	logic [1:0] ld_mode, next_ld_mode;
	logic [7:0] ld_ptr, next_ld_ptr;
	logic fuse_vld, next_fuse_rd, next_rem_req, next_hpd_oe;
	logic ld_we;
	logic [7:0] ld_wdata;

	always_comb begin
		next_ld_state = ld_state;
		next_ld_mode = ld_mode;
		next_ld_ptr = ld_ptr;
		next_fuse_rd = 1'b0;
		next_rem_req = rem_req_o;
		ld_we = 1'b0;
		ld_wdata = fuse_data_i;
		unique case (ld_state)
			LD_START: begin
				next_ld_mode = mode_now;
				next_ld_ptr = 8'h00;
				if (mode_now == EDP_MODE_FUSE) begin
					next_ld_state = LD_FUSE;
					next_fuse_rd = 1'b1;
				end else if (mode_now == EDP_MODE_REMOTE) begin
					next_ld_state = LD_REM;
					next_rem_req = 1'b1;
				end else begin
					next_ld_state = LD_READY;
				end
			end
			LD_FUSE: begin
				if (fuse_vld) begin
					ld_we = 1'b1;
					if (ld_ptr == EDP_LAST_BYTE) begin
						next_ld_state = LD_READY;
					end else begin
						next_ld_ptr = ld_ptr + 8'h01;
						next_fuse_rd = 1'b1;
					end
				end
			end
			LD_REM: begin
				ld_wdata = rem_data_i;
				if (rem_err_i) begin
					next_ld_ptr = 8'h00;
				end else if (rem_ack_i) begin
					ld_we = 1'b1;
					if (ld_ptr == EDP_LAST_BYTE) begin
						next_ld_state = LD_READY;
						next_rem_req = 1'b0;
					end else begin
						next_ld_ptr = ld_ptr + 8'h01;
					end
				end
			end
			LD_READY: begin end
		endcase
		if (ld_state != LD_START && mode_now != ld_mode) begin
			next_ld_state = LD_START;
			next_rem_req = 1'b0;
			next_fuse_rd = 1'b0;
			ld_we = 1'b0;
		end
		next_hpd_oe = !(pwr_s && ld_state == LD_READY);
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ld_state <= LD_START;
			ld_mode <= EDP_MODE_EEPROM;
			ld_ptr <= 8'h00;
			fuse_rd_o <= 1'b0;
			fuse_vld <= 1'b0;
			rem_req_o <= 1'b0;
			hpd_oe_o <= 1'b1;
			load_done_o <= 1'b0;
		end else begin
			ld_state <= next_ld_state;
			ld_mode <= next_ld_mode;
			ld_ptr <= next_ld_ptr;
			fuse_rd_o <= next_fuse_rd;
			fuse_vld <= fuse_rd_o;
			rem_req_o <= next_rem_req;
			hpd_oe_o <= next_hpd_oe;
			load_done_o <= (next_ld_state == LD_READY);
		end
	end
	assign fuse_addr_o = ld_ptr;
	assign rem_addr_o = ld_ptr;
	assign rem_dev_o = EDP_REM_DEV;
	assign hpd_o = 1'b0;

	// store: loader writes win; the control port owns it once ready
	always_ff @(posedge sys_clk_i) begin
		if (ld_we) begin
			mem[ld_ptr] <= ld_wdata;
		end else if (lm_wr_i && ld_state == LD_READY) begin
			mem[lm_addr_i] <= lm_wdata_i;
		end
	end
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lm_rdata_o <= 8'h00;
		end else if (lm_rd_i) begin
			lm_rdata_o <= mem[lm_addr_i];
		end
	end

	// ddc slave, or pass-through to the local eeprom
	edp_ds_t ds_state, next_ds_state;
	logic [3:0] bitc, next_bitc;
	logic [7:0] sh, next_sh, dptr, next_dptr;
	logic rw, next_rw, next_sda_oe, next_eep_scl_oe, next_eep_sda_oe, eep_mode;
	logic [1:0] ddc_hist, eep_hist;

	assign eep_mode = (ld_mode == EDP_MODE_EEPROM);

	always_comb begin
		next_ds_state = ds_state;
		next_bitc = bitc;
		next_sh = sh;
		next_dptr = dptr;
		next_rw = rw;
		next_sda_oe = ddc_sda_oe_o;
		// own pull comes back through the synchroniser late; mask it that long or the echo rings
		next_eep_scl_oe = eep_mode & ~scl_s;
		next_eep_sda_oe = eep_mode & ~sda_s & ~ddc_sda_oe_o & ~(|ddc_hist);
		if (eep_mode) begin
			next_ds_state = DS_IDLE;
			next_sda_oe = ~eep_sda_s & ~eep_sda_oe_o & ~(|eep_hist);
		end else if (stop_ev) begin
			next_ds_state = DS_IDLE;
			next_sda_oe = 1'b0;
		end else if (start_ev) begin
			next_ds_state = DS_DEV;
			next_bitc = 4'h0;
			next_sda_oe = 1'b0;
		end else begin
			unique case (ds_state)
				DS_IDLE: begin end
				DS_DEV, DS_OFF: begin
					if (rise_ev && bitc != EDP_BYTE_BITS) begin
						next_sh = {sh[6:0], sda_s};
						next_bitc = bitc + 4'h1;
					end else if (fall_ev && bitc == EDP_BYTE_BITS) begin
						next_bitc = 4'h0;
						if (ds_state == DS_OFF) begin
							next_dptr = sh;
							next_sda_oe = 1'b1;
							next_ds_state = DS_OACK;
						end else if (sh[7:1] == EDP_DDC_DEV) begin
							next_rw = sh[0];
							next_sda_oe = 1'b1;
							next_ds_state = DS_DACK;
						end else begin
							next_ds_state = DS_IDLE;
						end
					end
				end
				DS_OACK: begin
					if (fall_ev) begin
						next_sda_oe = 1'b0;
						next_ds_state = DS_IDLE;
					end
				end
				DS_DACK, DS_RNXT: begin
					if (fall_ev) begin
						if (ds_state == DS_DACK && !rw) begin
							next_sda_oe = 1'b0;
							next_ds_state = DS_OFF;
						end else begin
							next_sh = mem[dptr];
							next_sda_oe = ~mem[dptr][7];
							next_bitc = 4'h1;
							next_ds_state = DS_RD;
						end
					end
				end
				DS_RD: begin
					if (fall_ev) begin
						if (bitc == EDP_BYTE_BITS) begin
							next_sda_oe = 1'b0;
							next_dptr = dptr + 8'h01;
							next_ds_state = DS_RACK;
						end else begin
							next_sh = {sh[6:0], 1'b0};
							next_sda_oe = ~sh[6];
							next_bitc = bitc + 4'h1;
						end
					end
				end
				DS_RACK: begin
					if (rise_ev) begin
						next_ds_state = sda_s ? DS_IDLE : DS_RNXT;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ds_state <= DS_IDLE;
			bitc <= 4'h0;
			sh <= 8'h00;
			dptr <= 8'h00;
			rw <= 1'b0;
			ddc_sda_oe_o <= 1'b0;
			eep_scl_oe_o <= 1'b0;
			eep_sda_oe_o <= 1'b0;
			ddc_hist <= 2'h0;
			eep_hist <= 2'h0;
		end else begin
			ds_state <= next_ds_state;
			bitc <= next_bitc;
			sh <= next_sh;
			dptr <= next_dptr;
			rw <= next_rw;
			ddc_sda_oe_o <= next_sda_oe;
			eep_scl_oe_o <= next_eep_scl_oe;
			eep_sda_oe_o <= next_eep_sda_oe;
			ddc_hist <= {ddc_hist[0], ddc_sda_oe_o};
			eep_hist <= {eep_hist[0], eep_sda_oe_o};
		end
	end
endmodule : edp_ddc_top

// file: edp_ddc_top_test.sv
// self-checking bench for the edid provisioning top
`timescale 1ns/10ps
module edp_ddc_top_test import edp_pkg::*;;
	logic sys_clk_i = 1'b0;
	logic rstn_i, mode_ovr_en_i, lm_wr_i, lm_rd_i, eep_pull;
	logic ddc_scl_i, ddc_sda_i, ddc_sda_oe_o, eep_scl_oe_o, eep_sda_oe_o, hpd_o, hpd_oe_o;
	logic load_done_o, fuse_rd_o, rem_req_o, pwr5v_i, a;
	logic rem_ack_i = 1'b0, rem_err_i = 1'b0, erf = 1'b1;
	logic [1:0] mode_sel_i, mode_ovr_i;
	logic [6:0] rem_dev_o;
	logic [7:0] lm_addr_i, lm_wdata_i, lm_rdata_o, fuse_addr_o, rem_addr_o, r;
	logic [7:0] fuse_data_i = 8'h00, rem_data_i = 8'h00;
	logic [15:0] rows [4] = '{16'h005a, 16'h015b, 16'h7f25, 16'hffa5};
	int num_errors = 0, n_tests = 0, cyc = 0;
	// local eeprom wire: our own pull plus an eeprom that the bench can make pull low
	wire logic eep_sda_i = ~(eep_sda_oe_o | eep_pull);
	edp_ddc_top dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ddc_scl_i(ddc_scl_i),
		.ddc_sda_i(ddc_sda_i), .ddc_sda_oe_o(ddc_sda_oe_o), .eep_sda_i(eep_sda_i),
		.eep_scl_oe_o(eep_scl_oe_o), .eep_sda_oe_o(eep_sda_oe_o), .mode_sel_i(mode_sel_i),
		.mode_ovr_en_i(mode_ovr_en_i), .mode_ovr_i(mode_ovr_i), .pwr5v_i(pwr5v_i),
		.hpd_o(hpd_o), .hpd_oe_o(hpd_oe_o), .load_done_o(load_done_o), .lm_wr_i(lm_wr_i),
		.lm_rd_i(lm_rd_i), .lm_addr_i(lm_addr_i), .lm_wdata_i(lm_wdata_i),
		.lm_rdata_o(lm_rdata_o), .fuse_rd_o(fuse_rd_o), .fuse_addr_o(fuse_addr_o),
		.fuse_data_i(fuse_data_i), .rem_req_o(rem_req_o), .rem_dev_o(rem_dev_o),
		.rem_addr_o(rem_addr_o), .rem_ack_i(rem_ack_i), .rem_err_i(rem_err_i),
		.rem_data_i(rem_data_i));
	edp_src_model src (.clk_i(sys_clk_i), .dut_oe_i(ddc_sda_oe_o), .scl_o(ddc_scl_i),
		.sda_o(ddc_sda_i), .pwr5v_o(pwr5v_i));
	initial forever #20 sys_clk_i = ~sys_clk_i;
	// fuse array and remote link answer; one lost arbitration at offset 0x10
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		fuse_data_i <= fuse_addr_o ^ 8'h5a;
		rem_data_i <= ~rem_addr_o;
		rem_err_i <= rem_req_o && erf && rem_addr_o == 8'h10 && !rem_err_i;
		rem_ack_i <= rem_req_o && !rem_ack_i && !(erf && rem_addr_o == 8'h10);
		if (rem_err_i) begin
			erf <= 1'b0;
		end
		if (cyc == 60000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] e);
		n_tests++;
		if (got !== e) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, e);
		end
	endtask : chk
	task automatic at(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : at
	task automatic lm_wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge sys_clk_i);
		lm_wr_i <= 1'b1;
		lm_addr_i <= ad;
		lm_wdata_i <= d;
		@(posedge sys_clk_i);
		lm_wr_i <= 1'b0;
	endtask : lm_wr
	task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
		@(posedge sys_clk_i);
		lm_rd_i <= 1'b1;
		lm_addr_i <= ad;
		@(posedge sys_clk_i);
		lm_rd_i <= 1'b0;
		#1;
		chk(lm_rdata_o, e);
	endtask : rd_chk
	task automatic wait_done();
		for (int i = 0; i < 2000 && load_done_o !== 1'b1; i++) begin
			at(1);
		end
		chk(8'(load_done_o), 8'h01);
	endtask : wait_done
	task automatic ddc_rd(input logic [7:0] off, input logic [7:0] e);
		src.cond(1'b1);
		src.xfer(8'ha0, 1'b1, r, a);
		chk(8'(a), 8'h00);
		src.xfer(off, 1'b1, r, a);
		src.cond(1'b1);
		src.xfer(8'ha1, 1'b1, r, a);
		src.xfer(8'hff, 1'b1, r, a);
		chk(r, e);
		src.cond(1'b0);
	endtask : ddc_rd
	task automatic stop_test();
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	initial begin
		rstn_i = 1'b0;
		mode_ovr_en_i = 1'b0;
		mode_sel_i = EDP_MODE_FUSE;
		mode_ovr_i = EDP_MODE_SRAM;
		lm_wr_i = 1'b0;
		lm_rd_i = 1'b0;
		lm_addr_i = 8'h00;
		lm_wdata_i = 8'h00;
		eep_pull = 1'b0;
		repeat (3) @(posedge sys_clk_i);
		chk(8'(hpd_oe_o), 8'h01);
		rstn_i <= 1'b1;
		src.power(1'b1);
		at(2);
		chk(8'(hpd_oe_o), 8'h01);
		wait_done();
		at(2);
		chk(8'(hpd_oe_o), 8'h00);
		foreach (rows[i]) begin
			rd_chk(rows[i][15:8], rows[i][7:0]);
		end
		lm_wr(8'h20, 8'hc3);
		rd_chk(8'h20, 8'hc3);
		src.power(1'b0);
		at(6);
		chk(8'(hpd_oe_o), 8'h01);
		src.power(1'b1);
		ddc_rd(8'h05, 8'h5f);
		src.cond(1'b1);
		src.xfer(8'ha2, 1'b1, r, a);
		chk(8'(a), 8'h01);
		src.cond(1'b0);
		@(posedge sys_clk_i);
		mode_ovr_en_i <= 1'b1;
		mode_ovr_i <= EDP_MODE_REMOTE;
		at(4);
		chk(8'(hpd_oe_o), 8'h01);
		lm_wr(8'h40, 8'h11);
		wait_done();
		rd_chk(8'h40, 8'hbf);
		rd_chk(8'h10, 8'hef);
		ddc_rd(8'h03, 8'hfc);
		@(posedge sys_clk_i);
		mode_ovr_en_i <= 1'b0;
		mode_sel_i <= EDP_MODE_EEPROM;
		src.hc(1'b0, 1'b0);
		at(5);
		chk(8'(eep_scl_oe_o), 8'h01);
		src.hc(1'b1, 1'b0);
		at(5);
		chk(8'(eep_scl_oe_o), 8'h00);
		@(posedge sys_clk_i);
		eep_pull <= 1'b1;
		at(5);
		chk(8'(ddc_sda_oe_o), 8'h01);
		chk(8'(eep_sda_oe_o), 8'h00);
		@(posedge sys_clk_i);
		eep_pull <= 1'b0;
		src.hc(1'b1, 1'b1);
		at(5);
		chk(8'(eep_sda_oe_o), 8'h01);
		chk(8'(ddc_sda_oe_o), 8'h00);
		src.hc(1'b1, 1'b0);
		at(8);
		chk(8'(eep_sda_oe_o), 8'h00);
		chk(8'(ddc_sda_oe_o), 8'h00);
		stop_test();
	end
endmodule : edp_ddc_top_test
bind edp_ddc_top edp_ddc_assertions chk_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
	.pwr5v_i(pwr5v_i), .hpd_o(hpd_o), .hpd_oe_o(hpd_oe_o), .load_done_o(load_done_o),
	.lm_rd_i(lm_rd_i), .lm_rdata_o(lm_rdata_o), .fuse_rd_o(fuse_rd_o),
	.fuse_addr_o(fuse_addr_o), .rem_req_o(rem_req_o), .rem_dev_o(rem_dev_o),
	.rem_addr_o(rem_addr_o), .rem_ack_i(rem_ack_i), .rem_err_i(rem_err_i));

// file: edp_pkg.sv
// constants shared by the display identification provisioning block
package edp_pkg;
	localparam logic [6:0] EDP_DDC_DEV = 7'h50;
	localparam logic [6:0] EDP_REM_DEV = 7'h50;
	localparam logic [7:0] EDP_LAST_BYTE = 8'hff;
	localparam logic [3:0] EDP_BYTE_BITS = 4'h8;
	localparam int EDP_SYNC_W = 6;
	localparam logic [1:0] EDP_MODE_EEPROM = 2'h0;
	localparam logic [1:0] EDP_MODE_SRAM = 2'h1;
	localparam logic [1:0] EDP_MODE_REMOTE = 2'h2;
	localparam logic [1:0] EDP_MODE_FUSE = 2'h3;
	typedef enum logic [1:0] {LD_START, LD_FUSE, LD_REM, LD_READY} edp_ld_t;
	typedef enum logic [2:0] {DS_IDLE, DS_DEV, DS_DACK, DS_OFF, DS_OACK, DS_RD, DS_RACK, DS_RNXT}
		edp_ds_t;
endpackage : edp_pkg

// file: edp_src_model.sv
// ddc source model: 5v supply and a bit-level i2c master
`timescale 1ns/10ps
module edp_src_model (
	input wire logic clk_i,
	input wire logic dut_oe_i,
	output logic scl_o,
	output logic sda_o,
	output logic pwr5v_o
);
	logic m_oe = 1'b0;
	assign sda_o = ~(m_oe | dut_oe_i);
	initial scl_o = 1'b1;
	initial pwr5v_o = 1'b0;
	task automatic power(input logic v);
		@(posedge clk_i);
		pwr5v_o <= v;
	endtask : power
	task automatic hc(input logic s, input logic o);
		repeat (8) @(posedge clk_i);
		scl_o <= s;
		m_oe <= o;
	endtask : hc
	// start when e is high, stop when low
	task automatic cond(input logic e);
		hc(1'b0, m_oe);
		hc(1'b0, !e);
		hc(1'b1, !e);
		hc(1'b1, e);
	endtask : cond
	task automatic bit_x(input logic b, output logic r);
		hc(1'b0, m_oe);
		hc(1'b0, !b);
		hc(1'b1, !b);
		repeat (8) @(posedge clk_i);
		r = sda_o;
	endtask : bit_x
	task automatic xfer(input logic [7:0] w, input logic ak, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_x(w[i], r[i]);
		end
		bit_x(ak, a);
	endtask : xfer
endmodule : edp_src_model
